//--- design/tcc_pkg.sv
// Purpose: Constants and types for the timer capture and compare block.
// Assumes: AHB-Lite word registers with the 8-bit value in the low bits.
// Notes: Mode sets are 16-bit masks indexed by the waveform mode field.
package tcc_pkg;
    localparam logic [7:0] OFF_CTRL_A = 8'h00;
    localparam logic [7:0] OFF_CTRL_B = 8'h04;
    localparam logic [7:0] OFF_CTRL_D = 8'h08;
    localparam logic [7:0] OFF_FORCE = 8'h0c;
    localparam logic [7:0] OFF_CNT_LO = 8'h10;
    localparam logic [7:0] OFF_CNT_HI = 8'h14;
    localparam logic [7:0] OFF_CAP_LO = 8'h18;
    localparam logic [7:0] OFF_CAP_HI = 8'h1c;
    localparam logic [7:0] OFF_CMPA_LO = 8'h20;
    localparam logic [7:0] OFF_CMPA_HI = 8'h24;
    localparam logic [7:0] OFF_CMPB_LO = 8'h28;
    localparam logic [7:0] OFF_CMPB_HI = 8'h2c;
    localparam logic [7:0] OFF_FLAGS = 8'h30;
    localparam logic [7:0] OFF_IRQ_EN = 8'h34;
    localparam logic [7:0] OFF_COMP_CTRL = 8'h38;
    localparam int BIT_COM_A = 6;
    localparam int BIT_COM_B = 4;
    localparam int BIT_WGM_LO = 0;
    localparam int BIT_FILT_EN = 7;
    localparam int BIT_EDGE_RISE = 6;
    localparam int BIT_WGM_HI = 3;
    localparam int BIT_PSEL_A = 0;
    localparam int BIT_PSEL_B = 4;
    localparam int BIT_FORCE_A = 7;
    localparam int BIT_FORCE_B = 6;
    localparam int BIT_FLAG_CAP = 5;
    localparam int BIT_FLAG_A = 1;
    localparam int BIT_FLAG_B = 2;
    localparam int BIT_CAP_SEL = 2;
    localparam logic [15:0] MODES_PWM = 16'hcfee;
    localparam logic [15:0] MODES_CAP_TOP = 16'h5500;
    localparam logic [15:0] MODES_A_TOP = 16'h8a10;
    localparam logic [15:0] MODES_DUAL = 16'h0f0e;
    localparam logic [15:0] MODES_UPD_TOP = 16'h0c0e;
    localparam logic [15:0] MODES_TOP_8 = 16'h0022;
    localparam logic [15:0] MODES_TOP_9 = 16'h0044;
    localparam logic [15:0] MODES_TOP_10 = 16'h0088;
    localparam logic [15:0] TOP_8 = 16'h00ff;
    localparam logic [15:0] TOP_9 = 16'h01ff;
    localparam logic [15:0] TOP_10 = 16'h03ff;
    localparam logic [15:0] TOP_MAX = 16'hffff;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    typedef struct packed {
        logic [3:0] wgm;
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic filt_en;
        logic edge_rise;
        logic psel_a;
        logic psel_b;
        logic cap_sel;
    } tcc_ctrl_t;
endpackage

//--- design/tcc_top.sv
// Purpose: Input capture and two output compare channels of a 16-bit timer.
// Assumes: All inputs synchronous to clk_sys_i; timer_tick_i is the prescaled tick.
// Notes: Registers sit on AHB-Lite; reads take one wait state, writes none.
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module tcc_top #(
    parameter int FILT_LEN = 4
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic timer_tick_i,
    input wire logic capture_input_pin_i,
    input wire logic comparator_output_i,
    input wire logic [1:0] port_out_i,
    input wire logic [2:0] irq_ack_i,
    output logic [1:0] compare_output_pin_o,
    output logic [1:0] pin_override_o,
    output logic [2:0] irq_req_o
);
    generate
        if (FILT_LEN < 2 || FILT_LEN > 8) begin : g_bad_filt
            $error("FILT_LEN must lie between 2 and 8.");
        end
    endgenerate

    logic [7:0] ctl_a_q, ctl_b_q, ctl_d_q, comp_q, irq_en_q, temp_q;
    logic [15:0] counter_q, capture_q, top;
    logic [15:0] cmp_q [2];
    logic [15:0] buf_q [2];
    logic [2:0] flag_q, flag_set, flag_clr;
    logic [1:0] oc_q, match, force_ev;
    logic [7:0] addr_q;
    logic wr_pend_q, rd_pend_q, down_q, block_q, at_top, top_hit, upd_ev, cnt_wr;
    logic [FILT_LEN-1:0] samp_q;
    logic filt_q, prev_q, level, cap_ev;
    logic [31:0] rdata;
    tcc_pkg::tcc_ctrl_t ctl;

    assign ctl.wgm = {ctl_b_q[tcc_pkg::BIT_WGM_HI+:2], ctl_a_q[tcc_pkg::BIT_WGM_LO+:2]};
    assign ctl.com_a = ctl_a_q[tcc_pkg::BIT_COM_A+:2];
    assign ctl.com_b = ctl_a_q[tcc_pkg::BIT_COM_B+:2];
    assign ctl.filt_en = ctl_b_q[tcc_pkg::BIT_FILT_EN];
    assign ctl.edge_rise = ctl_b_q[tcc_pkg::BIT_EDGE_RISE];
    assign ctl.psel_a = ctl_d_q[tcc_pkg::BIT_PSEL_A];
    assign ctl.psel_b = ctl_d_q[tcc_pkg::BIT_PSEL_B];
    assign ctl.cap_sel = comp_q[tcc_pkg::BIT_CAP_SEL];

    function automatic logic in_set(input logic [15:0] set, input logic [3:0] m);
        return set[m];
    endfunction

    // Bus address phase and one-wait-state read handshake.
    logic addr_ph;
    assign addr_ph = hsel_i && htrans_i[1] && hready_i;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= tcc_pkg::RST_BYTE;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            wr_pend_q <= addr_ph && hwrite_i;
            rd_pend_q <= addr_ph && !hwrite_i;
            hreadyout_o <= !(addr_ph && !hwrite_i);
            hresp_o <= 1'b0;
            if (addr_ph) begin
                addr_q <= (haddr_i[31:8] == 24'h00_0000) ? haddr_i[7:0] : 8'hff;
            end
        end
    end

    function automatic logic wen(input logic p, input logic [7:0] a, input logic [7:0] o);
        return p && (a == o);
    endfunction

    assign cnt_wr = wen(wr_pend_q, addr_q, tcc_pkg::OFF_CNT_LO);

    // Compare reads return the stored value directly, never the shared latch.
    always_comb begin
        rdata = 32'h0000_0000;
        case (addr_q)
            tcc_pkg::OFF_CTRL_A: rdata[7:0] = ctl_a_q;
            tcc_pkg::OFF_CTRL_B: rdata[7:0] = ctl_b_q;
            tcc_pkg::OFF_CTRL_D: rdata[7:0] = ctl_d_q;
            tcc_pkg::OFF_CNT_LO: rdata[7:0] = counter_q[7:0];
            tcc_pkg::OFF_CNT_HI: rdata[7:0] = temp_q;
            tcc_pkg::OFF_CAP_LO: rdata[7:0] = capture_q[7:0];
            tcc_pkg::OFF_CAP_HI: rdata[7:0] = temp_q;
            tcc_pkg::OFF_CMPA_LO: rdata[7:0] = in_set(tcc_pkg::MODES_PWM, ctl.wgm) ?
                buf_q[0][7:0] : cmp_q[0][7:0];
            tcc_pkg::OFF_CMPA_HI: rdata[7:0] = in_set(tcc_pkg::MODES_PWM, ctl.wgm) ?
                buf_q[0][15:8] : cmp_q[0][15:8];
            tcc_pkg::OFF_CMPB_LO: rdata[7:0] = in_set(tcc_pkg::MODES_PWM, ctl.wgm) ?
                buf_q[1][7:0] : cmp_q[1][7:0];
            tcc_pkg::OFF_CMPB_HI: rdata[7:0] = in_set(tcc_pkg::MODES_PWM, ctl.wgm) ?
                buf_q[1][15:8] : cmp_q[1][15:8];
            tcc_pkg::OFF_FLAGS: begin
                rdata[tcc_pkg::BIT_FLAG_CAP] = flag_q[0];
                rdata[tcc_pkg::BIT_FLAG_A] = flag_q[1];
                rdata[tcc_pkg::BIT_FLAG_B] = flag_q[2];
            end
            tcc_pkg::OFF_IRQ_EN: rdata[7:0] = irq_en_q;
            tcc_pkg::OFF_COMP_CTRL: rdata[7:0] = comp_q;
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            hrdata_o <= rdata;
        end
    end

    // Control registers.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl_a_q <= tcc_pkg::RST_BYTE;
            ctl_b_q <= tcc_pkg::RST_BYTE;
            ctl_d_q <= tcc_pkg::RST_BYTE;
            comp_q <= tcc_pkg::RST_BYTE;
            irq_en_q <= tcc_pkg::RST_BYTE;
        end else begin
            if (wen(wr_pend_q, addr_q, tcc_pkg::OFF_CTRL_A)) ctl_a_q <= hwdata_i[7:0];
            if (wen(wr_pend_q, addr_q, tcc_pkg::OFF_CTRL_B)) ctl_b_q <= hwdata_i[7:0];
            if (wen(wr_pend_q, addr_q, tcc_pkg::OFF_CTRL_D)) ctl_d_q <= hwdata_i[7:0];
            if (wen(wr_pend_q, addr_q, tcc_pkg::OFF_COMP_CTRL)) comp_q <= hwdata_i[7:0];
            if (wen(wr_pend_q, addr_q, tcc_pkg::OFF_IRQ_EN)) irq_en_q <= hwdata_i[7:0];
        end
    end

    // Shared high-byte latch: loaded by high writes and by low reads of live values.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            temp_q <= tcc_pkg::RST_BYTE;
        end else if (wr_pend_q && (addr_q == tcc_pkg::OFF_CNT_HI || addr_q == tcc_pkg::OFF_CAP_HI
                     || addr_q == tcc_pkg::OFF_CMPA_HI || addr_q == tcc_pkg::OFF_CMPB_HI)) begin
            temp_q <= hwdata_i[7:0];
        end else if (wen(rd_pend_q, addr_q, tcc_pkg::OFF_CNT_LO)) begin
            temp_q <= counter_q[15:8];
        end else if (wen(rd_pend_q, addr_q, tcc_pkg::OFF_CAP_LO)) begin
            temp_q <= capture_q[15:8];
        end
    end

    // Top value by mode; channel A or the capture register may define it.
    always_comb begin
        if (in_set(tcc_pkg::MODES_A_TOP, ctl.wgm)) top = cmp_q[0];
        else if (in_set(tcc_pkg::MODES_CAP_TOP, ctl.wgm)) top = capture_q;
        else if (in_set(tcc_pkg::MODES_TOP_8, ctl.wgm)) top = tcc_pkg::TOP_8;
        else if (in_set(tcc_pkg::MODES_TOP_9, ctl.wgm)) top = tcc_pkg::TOP_9;
        else if (in_set(tcc_pkg::MODES_TOP_10, ctl.wgm)) top = tcc_pkg::TOP_10;
        else top = tcc_pkg::TOP_MAX;
    end

    assign at_top = (counter_q == top) && !down_q;
    assign top_hit = timer_tick_i && at_top && !block_q;

    // Counter with write priority over clear and count.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            counter_q <= tcc_pkg::RST_WORD;
            down_q <= 1'b0;
        end else if (cnt_wr) begin
            counter_q <= {temp_q, hwdata_i[7:0]};
        end else if (timer_tick_i) begin
            if (in_set(tcc_pkg::MODES_DUAL, ctl.wgm)) begin
                if (!down_q && top_hit) begin
                    down_q <= 1'b1;
                    counter_q <= counter_q - 16'h0001;
                end else if (down_q && counter_q == tcc_pkg::RST_WORD) begin
                    down_q <= 1'b0;
                    counter_q <= counter_q + 16'h0001;
                end else begin
                    counter_q <= down_q ? counter_q - 16'h0001 : counter_q + 16'h0001;
                end
            end else begin
                down_q <= 1'b0;
                counter_q <= top_hit ? tcc_pkg::RST_WORD : counter_q + 16'h0001;
            end
        end
    end

    // A counter write blocks matches up to and including the next timer tick.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            block_q <= 1'b0;
        end else if (cnt_wr) begin
            block_q <= 1'b1;
        end else if (timer_tick_i) begin
            block_q <= 1'b0;
        end
    end

    // Buffer transfer point: bottom for dual-slope modes outside MODES_UPD_TOP, top otherwise.
    always_comb begin
        if (in_set(tcc_pkg::MODES_UPD_TOP, ctl.wgm)) upd_ev = top_hit;
        else if (in_set(tcc_pkg::MODES_DUAL, ctl.wgm))
            upd_ev = timer_tick_i && down_q && counter_q == tcc_pkg::RST_WORD;
        else upd_ev = top_hit;
        upd_ev = upd_ev && in_set(tcc_pkg::MODES_PWM, ctl.wgm);
    end

    // Compare registers and their buffers for both channels.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < 2; i++) begin
                cmp_q[i] <= tcc_pkg::RST_WORD;
                buf_q[i] <= tcc_pkg::RST_WORD;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (wen(wr_pend_q, addr_q, i == 0 ? tcc_pkg::OFF_CMPA_LO : tcc_pkg::OFF_CMPB_LO)) begin
                    buf_q[i] <= {temp_q, hwdata_i[7:0]};
                    if (!in_set(tcc_pkg::MODES_PWM, ctl.wgm)) begin
                        cmp_q[i] <= {temp_q, hwdata_i[7:0]};
                    end
                end
                if (upd_ev) begin
                    cmp_q[i] <= buf_q[i];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            match[i] = timer_tick_i && !block_q && (counter_q == cmp_q[i]);
        end
        force_ev[0] = wen(wr_pend_q, addr_q, tcc_pkg::OFF_FORCE) && hwdata_i[tcc_pkg::BIT_FORCE_A]
            && !in_set(tcc_pkg::MODES_PWM, ctl.wgm);
        force_ev[1] = wen(wr_pend_q, addr_q, tcc_pkg::OFF_FORCE) && hwdata_i[tcc_pkg::BIT_FORCE_B]
            && !in_set(tcc_pkg::MODES_PWM, ctl.wgm);
    end

    // Output state: mode bits are read live at each match.
    function automatic logic oc_next(input logic cur, input logic [1:0] com,
                                     input logic [3:0] m, input logic hit, input logic top_ev,
                                     input logic dn);
        logic r;
        r = cur;
        if (!in_set(tcc_pkg::MODES_PWM, m)) begin
            if (hit) begin
                case (com)
                    tcc_pkg::COM_TOGGLE: r = !cur;
                    tcc_pkg::COM_CLEAR: r = 1'b0;
                    tcc_pkg::COM_SET: r = 1'b1;
                    default: r = cur;
                endcase
            end
        end else if (com[1]) begin
            if (in_set(tcc_pkg::MODES_DUAL, m)) begin
                if (hit) r = dn ^ com[0];
            end else if (hit) begin
                r = !com[0];
            end else if (top_ev) begin
                r = com[0];
            end
        end
        return r;
    endfunction

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            oc_q <= 2'b00;
        end else begin
            // Mode changes alone never touch the state.
            oc_q[0] <= oc_next(oc_q[0], ctl.com_a, ctl.wgm, match[0] || force_ev[0], top_hit,
                               down_q);
            oc_q[1] <= oc_next(oc_q[1], ctl.com_b, ctl.wgm, match[1] || force_ev[1], top_hit,
                               down_q);
        end
    end

    // Pin source: waveform when mode bits are nonzero and the pin select is set.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            compare_output_pin_o <= 2'b00;
            pin_override_o <= 2'b00;
        end else begin
            pin_override_o[0] <= (ctl.com_a != tcc_pkg::COM_OFF) && ctl.psel_a;
            pin_override_o[1] <= (ctl.com_b != tcc_pkg::COM_OFF) && ctl.psel_b;
            compare_output_pin_o[0] <= ((ctl.com_a != tcc_pkg::COM_OFF) && ctl.psel_a) ?
                oc_q[0] : port_out_i[0];
            compare_output_pin_o[1] <= ((ctl.com_b != tcc_pkg::COM_OFF) && ctl.psel_b) ?
                oc_q[1] : port_out_i[1];
        end
    end

    // Capture input: source select, FILT_LEN-sample filter and edge detector.
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            samp_q <= '0;
            filt_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            samp_q <= {samp_q[FILT_LEN-2:0],
                       ctl.cap_sel ? comparator_output_i : capture_input_pin_i};
            if (&samp_q) filt_q <= 1'b1;
            else if (~|samp_q) filt_q <= 1'b0;
            prev_q <= level;
        end
    end

    assign level = ctl.filt_en ? filt_q : samp_q[0];
    assign cap_ev = !in_set(tcc_pkg::MODES_CAP_TOP, ctl.wgm) &&
        (ctl.edge_rise ? (level && !prev_q) : (!level && prev_q));

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            capture_q <= tcc_pkg::RST_WORD;
        end else if (cap_ev) begin
            capture_q <= counter_q;
        end else if (wen(wr_pend_q, addr_q, tcc_pkg::OFF_CAP_LO) &&
                     in_set(tcc_pkg::MODES_CAP_TOP, ctl.wgm)) begin
            capture_q <= {temp_q, hwdata_i[7:0]};
        end
    end

    // Flags: set wins over write-one clear and interrupt acknowledge.
    assign flag_set = {match[1], match[0], cap_ev};
    assign flag_clr = irq_ack_i | ({3{wen(wr_pend_q, addr_q, tcc_pkg::OFF_FLAGS)}} &
        {hwdata_i[tcc_pkg::BIT_FLAG_B], hwdata_i[tcc_pkg::BIT_FLAG_A],
         hwdata_i[tcc_pkg::BIT_FLAG_CAP]});

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flag_q <= 3'b000;
            irq_req_o <= 3'b000;
        end else begin
            flag_q <= flag_set | (flag_q & ~flag_clr);
            irq_req_o <= flag_q & ~flag_clr & {irq_en_q[tcc_pkg::BIT_FLAG_B],
                irq_en_q[tcc_pkg::BIT_FLAG_A], irq_en_q[tcc_pkg::BIT_FLAG_CAP]};
        end
    end
endmodule // tcc_top

//--- verif/tcc_top_sva.sv
// Purpose: Port checks for the timer capture and compare block.
// Assumes: One clock domain, active-low asynchronous reset.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
module tcc_top_sva #(
    parameter int FILT_LEN = 4
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic timer_tick_i,
    input wire logic capture_input_pin_i,
    input wire logic comparator_output_i,
    input wire logic [1:0] port_out_i,
    input wire logic [2:0] irq_ack_i,
    input wire logic [1:0] compare_output_pin_o,
    input wire logic [1:0] pin_override_o,
    input wire logic [2:0] irq_req_o
);
    logic go;
    assign go = hsel_i && htrans_i[1] && hready_i;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    property p_rd_wait;
        go && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_nowait;
        go && hwrite_i |=> hreadyout_o;
    endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_okay;
        hresp_o == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_rdata_hold;
        $past(hreadyout_o) |-> $stable(hrdata_o);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_irqa_tick;
        $rose(irq_req_o[1]) |-> $past(timer_tick_i, 2);
    endproperty
    a_irqa_tick: assert property (p_irqa_tick) else $error("irq A without tick");
    property p_irqb_tick;
        $rose(irq_req_o[2]) |-> $past(timer_tick_i, 2);
    endproperty
    a_irqb_tick: assert property (p_irqb_tick) else $error("irq B without tick");
    property p_acka;
        irq_ack_i[1] && !timer_tick_i |-> ##2 !irq_req_o[1];
    endproperty
    a_acka: assert property (p_acka) else $error("ack A kept request");
    property p_ackb;
        irq_ack_i[2] && !timer_tick_i |-> ##2 !irq_req_o[2];
    endproperty
    a_ackb: assert property (p_ackb) else $error("ack B kept request");
endmodule // tcc_top_sva
bind tcc_top tcc_top_sva #(.FILT_LEN(FILT_LEN)) u_sva (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .timer_tick_i(timer_tick_i), .capture_input_pin_i(capture_input_pin_i),
    .comparator_output_i(comparator_output_i), .port_out_i(port_out_i),
    .irq_ack_i(irq_ack_i), .compare_output_pin_o(compare_output_pin_o),
    .pin_override_o(pin_override_o), .irq_req_o(irq_req_o));

//--- verif/tcc_sig_src.sv
// Purpose: Far-side model driving the capture pin and comparator level.
// Assumes: Levels change just after a rising edge.
// Notes: Software duties such as flag clearing stay with the bench.
`timescale 1ns/1ps
module tcc_sig_src (
    input wire logic clk_i,
    output logic pin_o,
    output logic cmp_o
);
    initial begin
        pin_o = 1'b0;
        cmp_o = 1'b0;
    end
    // Port-driven pin levels act as capture triggers.
    task automatic drive(input logic pin, input logic cmp, input int hold);
        @(posedge clk_i);
        pin_o <= pin;
        cmp_o <= cmp;
        repeat (hold) @(posedge clk_i);
    endtask
endmodule // tcc_sig_src

//--- verif/tcc_top_test.sv
// Purpose: Self-checking bench for the timer capture and compare block.
// Assumes: AHB-Lite single word transfers, data in the low byte.
// Notes: Timer ticks come only from the bench, so the counter is still between steps.
`timescale 1ns/1ps
module tcc_top_test;
    logic clk_sys_i, resetn_i, hsel_i, hwrite_i, timer_tick_i, hreadyout_o, hresp_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o;
    logic [1:0] htrans_i, port_out_i, compare_output_pin_o, pin_override_o;
    logic [2:0] irq_ack_i, irq_req_o;
    logic capture_input_pin_i, comparator_output_i;
    int checked, mismatches, cycles;
    tcc_top #(.FILT_LEN(4)) u_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .timer_tick_i(timer_tick_i),
        .capture_input_pin_i(capture_input_pin_i), .comparator_output_i(comparator_output_i),
        .port_out_i(port_out_i), .irq_ack_i(irq_ack_i),
        .compare_output_pin_o(compare_output_pin_o), .pin_override_o(pin_override_o),
        .irq_req_o(irq_req_o));
    tcc_sig_src u_src (.clk_i(clk_sys_i), .pin_o(capture_input_pin_i),
        .cmp_o(comparator_output_i));
    always #2 clk_sys_i = ~clk_sys_i;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
            output logic [31:0] r);
        @(posedge clk_sys_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= {24'h00_0000, a};
        hwrite_i <= w;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= {24'h00_0000, d};
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic w16(input logic [7:0] a_lo, input logic [15:0] v);
        wr(a_lo + 8'h04, v[15:8]);
        wr(a_lo, v[7:0]);
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] m,
            input logic [7:0] e);
        logic [31:0] x;
        bus(1'b0, a, 8'h00, x);
        check(n, x & {24'h00_0000, m}, {24'h00_0000, e});
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            timer_tick_i <= 1'b1;
            @(posedge clk_sys_i);
            timer_tick_i <= 1'b0;
        end
    endtask
    // Two channels match in order; flags, requests, acknowledge and readback.
    task automatic t_match();
        wr(tcc_pkg::OFF_IRQ_EN, 8'h06);
        w16(tcc_pkg::OFF_CMPA_LO, 16'h0107);
        w16(tcc_pkg::OFF_CMPB_LO, 16'h0108);
        w16(tcc_pkg::OFF_CNT_LO, 16'h0105);
        rdc("cmpa_hi", tcc_pkg::OFF_CMPA_HI, 8'hff, 8'h01);
        rdc("cmpa_lo", tcc_pkg::OFF_CMPA_LO, 8'hff, 8'h07);
        ticks(4);
        rdc("flags_match", tcc_pkg::OFF_FLAGS, 8'h26, 8'h06);
        check("irq_req", {29'h0000_0000, irq_req_o}, 32'h0000_0006);
        @(posedge clk_sys_i);
        irq_ack_i <= 3'h6;
        @(posedge clk_sys_i);
        irq_ack_i <= 3'h0;
        rdc("flags_ack", tcc_pkg::OFF_FLAGS, 8'h06, 8'h00);
        check("irq_clear", {29'h0000_0000, irq_req_o}, 32'h0000_0000);
    endtask
    // A counter write equal to the compare value hides the next match.
    task automatic t_block();
        w16(tcc_pkg::OFF_CNT_LO, 16'h0107);
        ticks(1);
        rdc("flags_block", tcc_pkg::OFF_FLAGS, 8'h02, 8'h00);
    endtask
    // Force strobe, pin source selection, mode change and immediate mode bits.
    task automatic t_force();
        wr(tcc_pkg::OFF_CTRL_A, 8'h40);
        wr(tcc_pkg::OFF_CTRL_D, 8'h01);
        repeat (3) @(posedge clk_sys_i);
        check("override", {30'h0000_0000, pin_override_o}, 32'h0000_0001);
        check("pin_reset", {30'h0000_0000, compare_output_pin_o}, 32'h0000_0002);
        wr(tcc_pkg::OFF_FORCE, 8'h80);
        repeat (3) @(posedge clk_sys_i);
        check("pin_forced", {30'h0000_0000, compare_output_pin_o}, 32'h0000_0003);
        rdc("flags_force", tcc_pkg::OFF_FLAGS, 8'h02, 8'h00);
        wr(tcc_pkg::OFF_CTRL_B, 8'h08);
        repeat (3) @(posedge clk_sys_i);
        check("pin_mode", {30'h0000_0000, compare_output_pin_o}, 32'h0000_0003);
        wr(tcc_pkg::OFF_CTRL_A, 8'h00);
        repeat (3) @(posedge clk_sys_i);
        check("pin_port", {30'h0000_0000, compare_output_pin_o}, 32'h0000_0002);
        wr(tcc_pkg::OFF_CTRL_B, 8'h00);
    endtask
    // Pin captures on a rising then a falling edge, then a rising comparator capture, with overwrite.
    task automatic t_capture();
        wr(tcc_pkg::OFF_CTRL_B, 8'h40);
        w16(tcc_pkg::OFF_CNT_LO, 16'h1234);
        u_src.drive(1'b1, 1'b0, 12);
        rdc("cap_lo", tcc_pkg::OFF_CAP_LO, 8'hff, 8'h34);
        rdc("cap_hi", tcc_pkg::OFF_CAP_HI, 8'hff, 8'h12);
        rdc("cap_flag", tcc_pkg::OFF_FLAGS, 8'h20, 8'h20);
        wr(tcc_pkg::OFF_CTRL_B, 8'h00);
        wr(tcc_pkg::OFF_FLAGS, 8'h20);
        w16(tcc_pkg::OFF_CNT_LO, 16'h5678);
        u_src.drive(1'b0, 1'b0, 12);
        u_src.drive(1'b1, 1'b0, 12);
        rdc("cap_lo2", tcc_pkg::OFF_CAP_LO, 8'hff, 8'h78);
        rdc("cap_hi2", tcc_pkg::OFF_CAP_HI, 8'hff, 8'h56);
        wr(tcc_pkg::OFF_COMP_CTRL, 8'h04);
        wr(tcc_pkg::OFF_FLAGS, 8'h20);
        wr(tcc_pkg::OFF_CTRL_B, 8'h40);
        w16(tcc_pkg::OFF_CNT_LO, 16'h0abc);
        u_src.drive(1'b1, 1'b1, 12);
        rdc("cap_cmp", tcc_pkg::OFF_CAP_LO, 8'hff, 8'hbc);
        rdc("cap_flag2", tcc_pkg::OFF_FLAGS, 8'h20, 8'h20);
        wr(tcc_pkg::OFF_IRQ_EN, 8'h20);
        repeat (2) @(posedge clk_sys_i);
        check("irq_cap", {29'h0000_0000, irq_req_o}, 32'h0000_0001);
    endtask
    // With the filter on, a short pulse is dropped and a long one captured.
    task automatic t_filter();
        wr(tcc_pkg::OFF_COMP_CTRL, 8'h00);
        wr(tcc_pkg::OFF_CTRL_B, 8'hc0);
        u_src.drive(1'b0, 1'b1, 12);
        wr(tcc_pkg::OFF_FLAGS, 8'h20);
        u_src.drive(1'b1, 1'b1, 2);
        u_src.drive(1'b0, 1'b1, 12);
        rdc("filt_short", tcc_pkg::OFF_FLAGS, 8'h20, 8'h00);
        u_src.drive(1'b1, 1'b1, 12);
        rdc("filt_long", tcc_pkg::OFF_FLAGS, 8'h20, 8'h20);
    endtask
    initial begin
        clk_sys_i = 1'b0;
        resetn_i = 1'b0;
        hsel_i = 1'b0;
        hwrite_i = 1'b0;
        htrans_i = 2'h0;
        haddr_i = 32'h0000_0000;
        hwdata_i = 32'h0000_0000;
        timer_tick_i = 1'b0;
        port_out_i = 2'h2;
        irq_ack_i = 3'h0;
        checked = 0;
        mismatches = 0;
        repeat (12) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
        check("irq_rst", {29'h0000_0000, irq_req_o}, 32'h0000_0000);
        t_match();
        t_block();
        t_force();
        t_capture();
        t_filter();
        print_verdict();
    end
endmodule // tcc_top_test
